// File: rtl/gar_aux_reset.sv
// Auxiliary command register with pon and chip reset, AXI4-Lite slave
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module gar_aux_reset (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             local_pon,
    output logic             sys_ctrl_enable,
    output logic             rsc_msg,
    output logic             par_poll_flag,
    output logic             send_eoi_pending,
    output logic [7:0]       serial_poll_response_reg
);
    import gar_pkg::*;

    // Write channel capture; address and data may come in either order
    logic        aw_held;
    logic        w_held;
    logic [7:0]  aw_addr;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    // Registered command strobe, acted on one cycle after the write
    logic        cmd_go;
    logic [4:0]  cmd_code;
    logic [4:0]  cfg_a;
    logic [4:0]  cfg_b;
    logic [4:0]  cfg_e;
    logic [3:0]  clock_count_register;
    logic [4:0]  ppr;
    // Marks a pon raised only for one cycle by immediate pon
    logic        pon_pulse;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;

    wire        aw_now   = aw_held || (s_axi_awvalid && s_axi_awready);
    wire        w_now    = w_held || (s_axi_wvalid && s_axi_wready);
    wire [7:0]  wr_addr  = aw_held ? aw_addr : s_axi_awaddr;
    wire [31:0] wr_data  = w_held ? w_data : s_axi_wdata;
    wire [3:0]  wr_strb  = w_held ? w_strb : s_axi_wstrb;
    wire        wr_fire  = aw_now && w_now && !s_axi_bvalid;
    wire        wr_lane0 = wr_fire && wr_strb[0];

    // Register decode
    wire        hit_aux  = wr_addr == ADDR_AUX_CMD;
    wire        hit_spr  = wr_addr == ADDR_SPOLL;
    wire        hit_ctrl = wr_addr == ADDR_CTRL;
    wire        wr_known = hit_aux || hit_spr || hit_ctrl || wr_addr == ADDR_STATUS
                           || wr_addr == ADDR_CFG_A || wr_addr == ADDR_CFG_B
                           || wr_addr == ADDR_CFG_E || wr_addr == ADDR_CLK_CNT
                           || wr_addr == ADDR_PPR;
    wire [2:0]  ctl_sel  = wr_data[CTL_MSB:CTL_LSB];
    wire [4:0]  cmd_fld  = wr_data[CMD_MSB:CMD_LSB];
    wire        aux_wr   = wr_lane0 && hit_aux;
    wire        is_cmd   = aux_wr && ctl_sel == CTL_COMMAND; // R1
    wire        hid_wr   = aux_wr && ctl_sel != CTL_COMMAND; // R1

    // Command decode, one cycle after the write
    wire        do_pon   = cmd_go && cmd_code == CMD_PON;        // R2
    wire        do_chip  = cmd_go && cmd_code == CMD_CHIP_RESET; // R2

    // AXI write handshake state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_addr      <= 8'h00;
            w_data       <= 32'h0;
            w_strb       <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            aw_held <= aw_now && !wr_fire;
            w_held  <= w_now && !wr_fire;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Command pipeline stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmd_go   <= 1'b0;
            cmd_code <= 5'h00;
        end else begin
            cmd_go   <= is_cmd;
            cmd_code <= cmd_fld;
        end
    end

    // Hidden registers; chip reset clears A, B and E and loads the clock count with 8
    gar_field_reg #(.WIDTH(5), .CLEAR_VAL(5'h00)) u_cfg_a (
        .clk   (clk),
        .rst   (rst),
        .load  (hid_wr && ctl_sel == CTL_CFG_A),
        .clear (do_chip), // R8
        .din   (cmd_fld),
        .q     (cfg_a)
    );
    gar_field_reg #(.WIDTH(5), .CLEAR_VAL(5'h00)) u_cfg_b (
        .clk   (clk),
        .rst   (rst),
        .load  (hid_wr && ctl_sel == CTL_CFG_B),
        .clear (do_chip), // R8
        .din   (cmd_fld),
        .q     (cfg_b)
    );
    gar_field_reg #(.WIDTH(5), .CLEAR_VAL(5'h00)) u_cfg_e (
        .clk   (clk),
        .rst   (rst),
        .load  (hid_wr && ctl_sel == CTL_CFG_E),
        .clear (do_chip), // R8
        .din   (cmd_fld),
        .q     (cfg_e)
    );
    gar_field_reg #(.WIDTH(4), .CLEAR_VAL(CLK_CNT_RESET)) u_clk_cnt (
        .clk   (clk),
        .rst   (rst),
        .load  (hid_wr && ctl_sel == CTL_CLK_CNT),
        .clear (do_chip), // R10
        .din   (cmd_fld[3:0]),
        .q     (clock_count_register)
    );
    // Parallel poll register is not named among chip reset effects
    gar_field_reg #(.WIDTH(5), .CLEAR_VAL(5'h00)) u_ppr (
        .clk   (clk),
        .rst   (rst),
        .load  (hid_wr && ctl_sel == CTL_PPR),
        .clear (1'b0),
        .din   (cmd_fld),
        .q     (ppr)
    );

    // Pon: reset and chip reset hold it; immediate pon releases a held pon,
    // and with none held it gives a one-cycle pon so functions still go idle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            local_pon <= 1'b1;
            pon_pulse <= 1'b0;
        end else if (do_chip) begin
            local_pon <= 1'b1; // R5 R6
            pon_pulse <= 1'b0;
        end else if (do_pon) begin
            local_pon <= !local_pon; // R3 R4
            pon_pulse <= !local_pon; // R3
        end else if (pon_pulse) begin
            local_pon <= 1'b0;
            pon_pulse <= 1'b0;
        end
    end

    // Local messages and control bits; chip reset wins over the write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sys_ctrl_enable          <= 1'b0;
            rsc_msg                  <= 1'b0;
            par_poll_flag            <= 1'b0;
            send_eoi_pending         <= 1'b0;
            serial_poll_response_reg <= 8'h00;
        end else if (do_chip) begin
            sys_ctrl_enable          <= 1'b0;  // R5
            rsc_msg                  <= 1'b0;  // R9
            par_poll_flag            <= 1'b0;  // R9
            send_eoi_pending         <= 1'b0;  // R7
            serial_poll_response_reg <= 8'h00; // R7
        end else begin
            if (wr_lane0 && hit_ctrl) begin
                sys_ctrl_enable <= wr_data[CTRL_SC_BIT];
                rsc_msg         <= wr_data[CTRL_RSC_BIT];
            end else if (cmd_go && cmd_code == CMD_DIS_SC) begin
                sys_ctrl_enable <= 1'b0;
            end
            if (wr_lane0 && hit_spr) begin
                serial_poll_response_reg <= wr_data[7:0];
            end
            if (cmd_go && (cmd_code == CMD_PPF_CLR || cmd_code == CMD_PPF_SET)) begin
                par_poll_flag <= cmd_code[3];
            end
            if (cmd_go && cmd_code == CMD_SEND_EOI) begin
                send_eoi_pending <= 1'b1;
            end
        end
    end

    // Read path; one read at a time, data one cycle after address
    wire [7:0]  status_bits = {3'h0, rsc_msg, sys_ctrl_enable, send_eoi_pending,
                               par_poll_flag, local_pon};
    wire        rd_known    = s_axi_araddr != ADDR_AUX_CMD;
    logic [31:0] rd_mux;
    always_comb begin
        unique case (s_axi_araddr)
            ADDR_SPOLL:   rd_mux = {24'h0, serial_poll_response_reg};
            ADDR_CFG_A:   rd_mux = {27'h0, cfg_a};
            ADDR_CFG_B:   rd_mux = {27'h0, cfg_b};
            ADDR_CFG_E:   rd_mux = {27'h0, cfg_e};
            ADDR_CLK_CNT: rd_mux = {28'h0, clock_count_register};
            ADDR_PPR:     rd_mux = {27'h0, ppr};
            ADDR_CTRL:    rd_mux = {30'h0, rsc_msg, sys_ctrl_enable};
            ADDR_STATUS:  rd_mux = {24'h0, status_bits};
            default:      rd_mux = 32'h0;
        endcase
    end
    wire rd_known_map = rd_known && (s_axi_araddr[1:0] == 2'h0) && s_axi_araddr <= ADDR_STATUS;

    assign s_axi_arready = !s_axi_rvalid;

    // Read response register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_known_map ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // gar_aux_reset

// File: rtl/gar_pkg.sv
// Constants for the auxiliary reset command block
// Summary of operation
// [R1] A write with a zero control field runs the command in the command field, else loads a hidden register.
// [R2] Command code 00000 is immediate-execute pon and 00010 is chip reset, acted on the cycle after the write.
// [R3] Immediate-execute pon drives local pon so every bus interface function goes to its idle state.
// [R4] Immediate-execute pon while pon is already held by reset or chip reset releases pon.
// [R5] Chip reset acts like the external reset and also clears the system-controller enable bit.
// [R6] Chip reset places all bus interface functions in their idle states.
// [R7] Chip reset clears the serial poll response register and the pending send-EOI bit.
// [R8] Chip reset clears auxiliary configuration registers A, B and E.
// [R9] Chip reset clears the parallel poll flag and the rsc local message.
// [R10] Chip reset loads the clock count register with binary 1000.
// [R11] The host must issue immediate-execute pon after chip reset before expecting bus activity.
package gar_pkg;
    // AXI4-Lite byte addresses
    localparam logic [7:0] ADDR_AUX_CMD    = 8'h00;
    localparam logic [7:0] ADDR_SPOLL      = 8'h04;
    localparam logic [7:0] ADDR_CFG_A      = 8'h08;
    localparam logic [7:0] ADDR_CFG_B      = 8'h0c;
    localparam logic [7:0] ADDR_CFG_E      = 8'h10;
    localparam logic [7:0] ADDR_CLK_CNT    = 8'h14;
    localparam logic [7:0] ADDR_PPR        = 8'h18;
    localparam logic [7:0] ADDR_CTRL       = 8'h1c;
    localparam logic [7:0] ADDR_STATUS     = 8'h20;
    // Aux command field layout
    localparam int         CTL_MSB         = 7;
    localparam int         CTL_LSB         = 5;
    localparam int         CMD_MSB         = 4;
    localparam int         CMD_LSB         = 0;
    // Control select codes for commands and hidden registers
    localparam logic [2:0] CTL_COMMAND     = 3'h0;
    localparam logic [2:0] CTL_CFG_A       = 3'h4;
    localparam logic [2:0] CTL_CFG_B       = 3'h5;
    localparam logic [2:0] CTL_CFG_E       = 3'h6;
    localparam logic [2:0] CTL_CLK_CNT     = 3'h1;
    localparam logic [2:0] CTL_PPR         = 3'h3;
    // Command codes
    localparam logic [4:0] CMD_PON         = 5'h00;
    localparam logic [4:0] CMD_CHIP_RESET  = 5'h02;
    localparam logic [4:0] CMD_PPF_CLR     = 5'h01;
    localparam logic [4:0] CMD_PPF_SET     = 5'h09;
    localparam logic [4:0] CMD_SEND_EOI    = 5'h06;
    localparam logic [4:0] CMD_DIS_SC      = 5'h14;
    // Reset value and AXI response codes
    localparam logic [3:0] CLK_CNT_RESET   = 4'h8;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;
    // Control register bits
    localparam int         CTRL_SC_BIT     = 0;
    localparam int         CTRL_RSC_BIT    = 1;
    // Status register bits
    localparam int         ST_PON_BIT      = 0;
    localparam int         ST_PPF_BIT      = 1;
    localparam int         ST_EOI_BIT      = 2;
    localparam int         ST_SC_BIT       = 3;
    localparam int         ST_RSC_BIT      = 4;
endpackage

// File: rtl/gar_field_reg.sv
// Hidden register of WIDTH bits, loaded via aux command, set to CLEAR_VAL by clear
`timescale 1ns/1ps
module gar_field_reg #(
    parameter int        WIDTH = 5,
    parameter logic [WIDTH-1:0] CLEAR_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic             clear,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] q
);
    // Clear wins: chip reset must not be undone by a same-cycle load
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= CLEAR_VAL;
        end else if (clear) begin
            q <= CLEAR_VAL;
        end else if (load) begin
            q <= din;
        end
    end
endmodule // gar_field_reg

// File: dv/gar_aux_reset_monitor.sv
// Port checker for the aux reset command block
`timescale 1ns/1ps
module gar_aux_reset_monitor
    import gar_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        local_pon,
    input wire logic        sys_ctrl_enable,
    input wire logic        rsc_msg,
    input wire logic        par_poll_flag,
    input wire logic        send_eoi_pending,
    input wire logic [7:0]  serial_poll_response_reg
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Write take and aux command decode; effects are seen two samples later
    wire take     = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
    wire aux_take = take & s_axi_wstrb[0] & (s_axi_awaddr == ADDR_AUX_CMD);
    wire pon_cmd  = aux_take & (s_axi_wdata[7:0] == 8'h00);
    wire cr_cmd   = aux_take & (s_axi_wdata[7:0] == 8'h02);
    wire hid_cmd  = aux_take & (s_axi_wdata[7:5] != CTL_COMMAND);
    sequence s_cr_write;
        cr_cmd;
    endsequence
    sequence s_cr_done;
        ##2 (local_pon && !sys_ctrl_enable && !rsc_msg && !par_poll_flag
             && !send_eoi_pending && serial_poll_response_reg == 8'h00);
    endsequence
    a_write_answered: assert property (take |=> s_axi_bvalid) else $error("no write response");
    a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("arready while rvalid");
    a_pon_release: assert property (pon_cmd && local_pon |-> ##2 !local_pon)
        else $error("pon not released");
    a_pon_pulse: assert property (pon_cmd && !local_pon |-> ##2 local_pon ##1 !local_pon)
        else $error("no pon pulse");
    a_pon_fall_cause: assert property ($fell(local_pon) |-> $past(pon_cmd, 2) || $past(pon_cmd, 3))
        else $error("pon fell without command");
    a_pon_rise_cause: assert property ($rose(local_pon) |-> $past(cr_cmd, 2) || $past(pon_cmd, 2))
        else $error("pon rose without command");
    a_chip_reset_clears: assert property (s_cr_write |-> s_cr_done)
        else $error("chip reset left state");
    a_hidden_load_only: assert property (hid_cmd |-> ##3 local_pon == $past(local_pon, 3))
        else $error("hidden load ran a command");
endmodule // gar_aux_reset_monitor

bind gar_aux_reset gar_aux_reset_monitor gar_aux_reset_monitor_inst (.*);

// File: dv/gar_host_model.sv
// Host-side AXI4-Lite master for register and aux command cycles
`timescale 1ns/1ps
module gar_host_model (
    input  wire logic        clk,
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    int lag = 0; // Extra cycles before bready or rready, a slow host
    // Quiet bus at time zero
    initial begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    end
    // Ready is stable between edges, so the falling edge predicts the take
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa;
        logic pw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            pa = pa && !s_axi_awready;
            pw = pw && !s_axi_wready;
            @(posedge clk);
            s_axi_awvalid <= pa;
            s_axi_wvalid  <= pw;
        end
        s_axi_awaddr <= ~a; // Released lines must not keep the old value
        s_axi_wdata  <= ~d;
        repeat (lag) @(posedge clk);
        s_axi_bready <= 1'b1;
        do @(negedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask
    // One read, rready held until rvalid seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
        repeat (lag) @(posedge clk);
        s_axi_rready <= 1'b1;
        do @(negedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask
endmodule // gar_host_model

// File: dv/tb_top.sv
// Self-checking bench for the aux reset command block
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
    import gar_pkg::*;
    typedef struct packed {
        logic [7:0] wa;
        logic [7:0] wd;
        logic [7:0] ra;
        logic [7:0] rd;
    } gar_row_t;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    int               n_mismatch = 0;
    int               tests_run = 0;
    logic [1:0]       r;
    logic [31:0]      d;
    wire logic [7:0]  s_axi_awaddr, s_axi_araddr, serial_poll_response_reg;
    wire logic [31:0] s_axi_wdata, s_axi_rdata;
    wire logic [3:0]  s_axi_wstrb;
    wire logic [1:0]  s_axi_bresp, s_axi_rresp;
    wire logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    wire logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    wire logic        local_pon, sys_ctrl_enable, rsc_msg, par_poll_flag, send_eoi_pending;
    // Write address/data, then read address and expected low byte
    gar_row_t rows [23] = '{
        '{8'h00, 8'h95, 8'h08, 8'h15}, '{8'h00, 8'haa, 8'h0c, 8'h0a},
        '{8'h00, 8'hdf, 8'h10, 8'h1f}, '{8'h00, 8'h23, 8'h14, 8'h03},
        '{8'h00, 8'h71, 8'h18, 8'h11}, '{8'h04, 8'ha5, 8'h04, 8'ha5},
        '{8'h1c, 8'h03, 8'h1c, 8'h03}, '{8'h00, 8'h00, 8'h20, 8'h18},
        '{8'h00, 8'h09, 8'h20, 8'h1a}, '{8'h00, 8'h06, 8'h20, 8'h1e},
        '{8'h00, 8'h00, 8'h20, 8'h1e}, '{8'h00, 8'h14, 8'h20, 8'h16},
        '{8'h00, 8'h01, 8'h20, 8'h14}, '{8'h00, 8'h02, 8'h20, 8'h01},
        '{8'h24, 8'h00, 8'h08, 8'h00}, '{8'h24, 8'h00, 8'h0c, 8'h00},
        '{8'h24, 8'h00, 8'h10, 8'h00}, '{8'h24, 8'h00, 8'h14, 8'h08},
        '{8'h24, 8'h00, 8'h04, 8'h00}, '{8'h24, 8'h00, 8'h1c, 8'h00},
        '{8'h24, 8'h00, 8'h00, 8'h00}, '{8'h00, 8'h00, 8'h18, 8'h11},
        '{8'h24, 8'h00, 8'h20, 8'h00}};
    gar_aux_reset  gar_aux_reset_inst (.*);
    gar_host_model gar_host_model_inst (.*);
    // 25 MHz clock
    always #20 clk = ~clk;
    // Single exit for both verdicts
    task automatic end_sim;
        $display("mismatches %0d of %0d comparisons", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        end_sim();
    end
    // Reset, table of cycles, then a reset in mid-run
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        `CHK("local_pon", 1'b1, local_pon)
        gar_host_model_inst.rd(ADDR_CLK_CNT, d, r);
        `CHK("clk_cnt", 32'h8, d)
        foreach (rows[i]) begin
            gar_host_model_inst.lag = i % 3;
            gar_host_model_inst.wr(rows[i].wa, {24'h0, rows[i].wd}, r);
            `CHK("bresp", (rows[i].wa == 8'h24 ? RESP_SLVERR : RESP_OKAY), r)
            gar_host_model_inst.rd(rows[i].ra, d, r);
            `CHK("rdata", {24'h0, rows[i].rd}, d)
            `CHK("rresp", (rows[i].ra == 8'h00 ? RESP_SLVERR : RESP_OKAY), r)
        end
        // Port view of what the chip reset in the table cleared
        `CHK("spoll_port", 8'h00, serial_poll_response_reg)
        `CHK("eoi_port", 1'b0, send_eoi_pending)
        `CHK("ppf_port", 1'b0, par_poll_flag)
        `CHK("rsc_port", 1'b0, rsc_msg)
        gar_host_model_inst.wr(ADDR_CTRL, 32'h1, r);
        `CHK("sc_set", 1'b1, sys_ctrl_enable)
        @(posedge clk);
        rst <= 1'b1;
        @(negedge clk);
        `CHK("pon_rst", 1'b1, local_pon)
        `CHK("sc_rst", 1'b0, sys_ctrl_enable)
        @(posedge clk);
        rst <= 1'b0;
        gar_host_model_inst.rd(ADDR_STATUS, d, r);
        `CHK("status_rst", 32'h1, d)
        end_sim();
    end
endmodule // tb_top
